// >>> verilog/usart_master_spi_mode.sv
// serial port reused as an spi master: divisor clock, 4 modes, 8-bit frames
// assumes control bits come from same-clock logic; serial_in_pin is a pin
// How it works
// R1 - master only; clock pin driven when output
// R2 - bit clock is osc over 2(div+1)
// R3 - divisor is 12 bits from two halves
// R4 - phase and polarity pick modes 0-3
// R5 - drive and sample on opposite clock edges
// R6 - software keeps mode bits steady mid-transfer
// R7 - eight bits, msb or lsb first shared
// R8 - next frame follows directly or line idles high
// R9 - two writes make 16 bits, one completion
// R10 - software zeros divisor when enabling transmitter
// R11 - divisor register resets to zero
// R12 - software checks idle before reconfiguring
// R13 - software clears completion flag before writing
// R14 - transmitter enable takes over serial output
// R15 - optional receiver takes over serial input
// R16 - receiving happens only while transmitting
// R17 - write starts transfer; buffer feeds shifter
// R18 - software reads once per byte sent
// R19 - overflow drops newest byte, keeps older
// R20 - software sets clock pin before enabling
// R21 - both mode selects high select spi master
// R22 - frame, overrun, parity flags read zero
// R23 - completion sets when done and buffer empty
// R24 - tx disable waits; rx disable flushes
// R25 - idle clock holds polarity level
`timescale 1ns/1ns
`include "spi_master_defines.svh"

module usart_master_spi_mode (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       mode_select_high,
    input  wire logic       mode_select_low,
    input  wire logic       clock_pin_direction,
    input  wire logic       transmitter_enable_bit,
    input  wire logic       receiver_enable_bit,
    input  wire logic [3:0] baud_divisor_high,
    input  wire logic [7:0] baud_divisor_low,
    input  wire logic       clock_phase_bit,
    input  wire logic       clock_polarity_bit,
    input  wire logic       data_order_bit,
    input  wire logic       data_wr,
    input  wire logic [7:0] data_wdata,
    input  wire logic       data_rd,
    output logic      [7:0] data_rdata,
    input  wire logic       txc_clear,
    output logic            transmit_complete_flag,
    output logic            receive_complete_flag,
    output logic            tx_buffer_empty_flag,
    output logic            frame_error_flag,
    output logic            data_overrun_flag,
    output logic            parity_error_flag,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin,
    output logic            serial_out_oe_n,
    output logic            serial_clock_pin,
    output logic            serial_clock_oe_n
);

    // physical bit position of logical bit k for the chosen order
    function automatic logic [2:0] bit_pos(input logic [2:0] k,
                                           input logic       lsb_first);
        bit_pos = lsb_first ? k : 3'h7 - k;
    endfunction

    spi_master_pkg::shift_state_t state_ff;
    spi_master_pkg::shift_state_t nxt_state;

    logic [`DIV_W-1:0] div_ff;
    logic [`DIV_W-1:0] cnt_ff;
    logic [3:0]        edge_ff;
    logic [7:0]        tx_sr_ff;
    logic [7:0]        rx_sr_ff;
    logic [7:0]        tx_buf_ff;
    logic              tx_full_ff;
    logic              txc_ff;
    logic [7:0]        rx0_ff;
    logic [7:0]        rx1_ff;
    logic [1:0]        rx_cnt_ff;
    logic              sin_meta_ff;
    logic              sin_ff;
    logic              tx_out_ff;
    logic              sck_ff;

    wire spi_mode;
    wire tx_run;
    wire rx_run;
    wire shifting;
    wire tick;
    wire frame_end;
    wire load;
    wire buf_wr;
    wire push;
    wire pop;
    wire [2:0] rx_bit;
    wire [2:0] tx_bit;
    wire [3:0] nxt_edge;
    wire [3:0] done_edge;
    wire tx_hold;

    // R21 spi mode select
    assign spi_mode = mode_select_high & mode_select_low;

    // R24 tx disable waits
    // transmitter stays alive until shifter and buffer drain
    assign tx_run = spi_mode &
                    (transmitter_enable_bit | shifting | tx_full_ff);
    // R16 receive needs transmit
    assign rx_run = spi_mode & receiver_enable_bit & tx_run;

    assign shifting = (state_ff == spi_master_pkg::ST_SHIFT);

    // R2 half period ticks
    // >= keeps a lowered divisor from stalling the frame
    assign tick = shifting & (cnt_ff >= div_ff);
    assign frame_end = tick & (edge_ff == `LAST_EDGE);
    assign nxt_edge = edge_ff + 4'h1;

    // R17 buffer to shifter
    assign load = tx_full_ff & (!shifting | frame_end);
    // write accepted only when transmitter enabled and buffer free
    assign buf_wr = data_wr & spi_mode & transmitter_enable_bit &
                    !tx_full_ff;

    // R4 sample index
    // sample bit e>>1 on leading (cpha 0) or trailing (cpha 1) edge
    assign rx_bit = bit_pos(edge_ff[3:1], data_order_bit);
    // R5 opposite edges
    // index from edges done after this clock, so data moves on the
    // setup edge itself and never on a sampling edge
    assign done_edge = tick ? nxt_edge : edge_ff;
    assign tx_bit = bit_pos(clock_phase_bit ?
                            ((done_edge == 4'h0) ? 3'h0 :
                             3'((done_edge - 4'h1) >> 1)) :
                            done_edge[3:1],
                            data_order_bit);
    // cpha 1 samples on the last edge, so the last bit stays a cycle
    assign tx_hold = frame_end & clock_phase_bit;

    wire sample_now;
    assign sample_now = tick & (edge_ff[0] == clock_phase_bit);

    // R15 receiver takes frame at end
    assign push = frame_end & rx_run;
    assign pop  = data_rd & (rx_cnt_ff != 2'h0);

    // state step
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            spi_master_pkg::ST_IDLE: begin
                if (load) begin
                    nxt_state = spi_master_pkg::ST_SHIFT;
                end
            end
            spi_master_pkg::ST_SHIFT: begin
                // R8 back to back
                if (frame_end & !tx_full_ff) begin
                    nxt_state = spi_master_pkg::ST_IDLE;
                end
            end
            default: nxt_state = spi_master_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= spi_master_pkg::ST_IDLE;
        end else if (!spi_mode) begin
            state_ff <= spi_master_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // R11 divisor reset zero
    // R3 twelve bit divisor
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_ff <= `DIV_RESET;
        end else begin
            div_ff <= {baud_divisor_high, baud_divisor_low};
        end
    end

    // R2 baud counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= `DIV_RESET;
        end else if (!shifting | tick) begin
            cnt_ff <= `DIV_RESET;
        end else begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end

    // R7 edge counter
    // sixteen edges make one eight bit frame
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edge_ff <= 4'h0;
        end else if (!shifting | load) begin
            edge_ff <= 4'h0;
        end else if (tick) begin
            edge_ff <= nxt_edge;
        end
    end

    // R17 transmit buffer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_buf_ff  <= `BYTE_RESET;
            tx_full_ff <= 1'b0;
        end else if (!spi_mode) begin
            tx_full_ff <= 1'b0;
        end else if (buf_wr) begin
            tx_buf_ff  <= data_wdata;
            tx_full_ff <= 1'b1;
        end else if (load) begin
            tx_full_ff <= 1'b0;
        end
    end

    // shift registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_sr_ff <= `BYTE_RESET;
            rx_sr_ff <= `BYTE_RESET;
        end else begin
            if (load) begin
                tx_sr_ff <= tx_buf_ff;
            end
            if (sample_now) begin
                rx_sr_ff[rx_bit] <= sin_ff;
            end
        end
    end

    // R23 completion flag
    // R9 one completion per pair
    // the set beats a clear arriving in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txc_ff <= 1'b0;
        end else if (frame_end & !tx_full_ff) begin
            txc_ff <= 1'b1;
        end else if (txc_clear) begin
            txc_ff <= 1'b0;
        end
    end

    // R19 overflow drops newest
    // R24 rx flush
    // with cpha 1 the last bit of the frame is taken from the sampler directly
    wire [7:0] rx_word;
    assign rx_word = sample_now ?
                     (rx_sr_ff & ~(8'h01 << rx_bit)) |
                     (8'({7'h00, sin_ff}) << rx_bit) :
                     rx_sr_ff;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx0_ff    <= `BYTE_RESET;
            rx1_ff    <= `BYTE_RESET;
            rx_cnt_ff <= 2'h0;
        end else if (!(spi_mode & receiver_enable_bit)) begin
            rx_cnt_ff <= 2'h0;
        end else begin
            unique case ({push & (rx_cnt_ff != `RX_DEPTH | pop), pop})
                2'b10: begin
                    if (rx_cnt_ff == 2'h0) begin
                        rx0_ff <= rx_word;
                    end else begin
                        rx1_ff <= rx_word;
                    end
                    rx_cnt_ff <= rx_cnt_ff + 2'h1;
                end
                2'b01: begin
                    rx0_ff    <= rx1_ff;
                    rx_cnt_ff <= rx_cnt_ff - 2'h1;
                end
                2'b11: begin
                    if (rx_cnt_ff == 2'h1) begin
                        rx0_ff <= rx_word;
                    end else begin
                        rx0_ff <= rx1_ff;
                        rx1_ff <= rx_word;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // input pin synchroniser, first stage read only by second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sin_meta_ff <= 1'b0;
            sin_ff      <= 1'b0;
        end else begin
            sin_meta_ff <= serial_in_pin;
            sin_ff      <= sin_meta_ff;
        end
    end

    // R8 idle high line
    // R25 idle clock level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_out_ff <= `LINE_IDLE;
            sck_ff    <= 1'b0;
        end else begin
            tx_out_ff <= tx_hold ? tx_out_ff :
                         (nxt_state == spi_master_pkg::ST_SHIFT &
                          spi_mode) ?
                         (load ? tx_buf_ff[bit_pos(3'h0, data_order_bit)] :
                          tx_sr_ff[tx_bit]) :
                         `LINE_IDLE;
            sck_ff    <= clock_polarity_bit ^
                         (shifting & !load & (tick ? nxt_edge[0] :
                                              edge_ff[0]));
        end
    end

    // pins and flags
    assign serial_out_pin    = tx_out_ff;
    assign serial_clock_pin  = sck_ff;
    // R14 output takeover
    assign serial_out_oe_n   = !tx_run;
    // R1 clock pin drive
    assign serial_clock_oe_n = !(spi_mode & clock_pin_direction);
    assign data_rdata        = rx0_ff;
    assign receive_complete_flag  = (rx_cnt_ff != 2'h0);
    assign transmit_complete_flag = txc_ff;
    assign tx_buffer_empty_flag   = !tx_full_ff;
    // R22 unused error flags
    assign frame_error_flag  = 1'b0;
    assign data_overrun_flag = 1'b0;
    assign parity_error_flag = 1'b0;

    // checks on the block's own outputs and internal state
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence frame_start_s;
        !shifting ##1 shifting;
    endsequence

    err_flags_a: assert property ( // R22
        !(frame_error_flag | data_overrun_flag | parity_error_flag))
        else $error("error flags not zero");
    sck_idle_a: assert property ( // R25
        !shifting ##1 !shifting |-> serial_clock_pin == $past(
        clock_polarity_bit))
        else $error("idle clock not at polarity level");
    start_level_a: assert property ( // R4
        frame_start_s |-> serial_clock_pin == $past(clock_polarity_bit))
        else $error("clock moved before first tick");
    txc_set_a: assert property ( // R23
        frame_end && !tx_full_ff |=> transmit_complete_flag)
        else $error("completion flag not set");
    back_back_a: assert property ( // R9
        frame_end && tx_full_ff && spi_mode |=> shifting &&
        !transmit_complete_flag || $past(txc_ff))
        else $error("second byte did not follow directly");
    line_idle_a: assert property ( // R8
        !shifting ##1 !shifting |-> serial_out_pin)
        else $error("data line not idle high");
    rx_flush_a: assert property ( // R24
        !receiver_enable_bit |=> !receive_complete_flag)
        else $error("receive buffer not flushed");
    overflow_a: assert property ( // R19
        rx_cnt_ff == 2'h2 && push && !pop && receiver_enable_bit
        |=> rx1_ff == $past(rx1_ff))
        else $error("overflow overwrote older byte");
    tx_oe_a: assert property ( // R14
        spi_mode && transmitter_enable_bit |-> !serial_out_oe_n)
        else $error("output pin not taken over");
    fast_tick_a: assert property ( // R2
        tick && !frame_end && spi_mode ##1 div_ff == 12'h000 |-> tick)
        else $error("zero divisor did not tick every cycle");

endmodule

// >>> verilog/spi_master_defines.svh
// constant values for the serial-port-as-spi-master block
// assumes inclusion by bare name from design files only
`ifndef SPI_MASTER_DEFINES_SVH
`define SPI_MASTER_DEFINES_SVH

// divisor width and reset value
`define DIV_W          12
`define DIV_RESET      12'h000
// bits per frame and index of the last edge of a frame
`define FRAME_BITS     8
`define LAST_EDGE      4'hF
// receive buffer depth (buffer plus one extra level)
`define RX_DEPTH       2'h2
// reset values of data holding registers
`define BYTE_RESET     8'h00
// idle level of the data line
`define LINE_IDLE      1'b1

`endif

// >>> verilog/spi_master_pkg.sv
// types shared by the serial-port-as-spi-master block
// assumes the defines header is compiled alongside
package spi_master_pkg;

    // shifter state, one-hot
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_t;

endpackage

// >>> test/spi_slave_model.sv
// spi slave model: shifts a preset byte out and collects what it sees
// assumes the master clock rests between frames and load marks a new one
`timescale 1ns/1ns
module spi_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       cpha,
    input  wire logic       lsb_first,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte,
    output int              frames
);
    int edges = 0;

    function automatic int pos(input int i);
        return lsb_first ? i : 7 - i;
    endfunction

    // a new frame restarts the count and shows bit 0 before any edge
    initial miso = 1'b1;
    initial frames = 0;
    always @(posedge load) begin
        edges = 0;
        miso = tx_byte[pos(0)];
    end

    // odd edges lead; phase picks sample or setup
    always @(sck) begin
        edges = edges + 1;
        if ((edges % 2 == 1) != cpha) begin
            rx_byte[pos((edges - 1) / 2)] = mosi;
        end else if (edges < 16) begin
            miso = tx_byte[pos(cpha ? (edges - 1) / 2 : edges / 2)];
        end
        // a following frame may start at once, so rewind here
        if (edges == 16) begin
            edges = 0;
            frames = frames + 1;
            miso = tx_byte[pos(0)];
        end
    end
endmodule

// >>> test/tb_usart_master_spi_mode.sv
// testbench: drives control bits and strobes, checks flags and pins
// assumes the slave model answers on the data lines of the port
`timescale 1ns/1ns
module tb_usart_master_spi_mode;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        mode_select_high = 1'b1;
    logic        mode_select_low = 1'b1;
    logic        clock_pin_direction = 1'b1;
    logic        transmitter_enable_bit = 1'b1;
    logic        receiver_enable_bit = 1'b0;
    logic [3:0]  baud_divisor_high = 4'h0;
    logic [7:0]  baud_divisor_low = 8'h00;
    logic        clock_phase_bit = 1'b0;
    logic        clock_polarity_bit = 1'b0;
    logic        data_order_bit = 1'b0;
    logic        data_wr = 1'b0;
    logic [7:0]  data_wdata = 8'h00;
    logic        data_rd = 1'b0;
    logic        txc_clear = 1'b0;
    logic        load = 1'b0;
    logic [7:0]  slave_tx = 8'h00;
    logic [7:0]  data_rdata, slave_rx;
    logic        transmit_complete_flag, receive_complete_flag;
    logic        tx_buffer_empty_flag, frame_error_flag;
    logic        data_overrun_flag, parity_error_flag, serial_in_pin;
    logic        serial_out_pin, serial_out_oe_n;
    logic        serial_clock_pin, serial_clock_oe_n;
    logic [15:0] half;
    time         t_edge = 0;
    int          frames, bad_count = 0, comparisons = 0;
    logic [7:0]  seen[$];

    always #50 ref_clk = ~ref_clk;

    usart_master_spi_mode usart_master_spi_mode_inst (.ref_clk, .rst,
        .mode_select_high, .mode_select_low, .clock_pin_direction,
        .transmitter_enable_bit, .receiver_enable_bit, .baud_divisor_high,
        .baud_divisor_low, .clock_phase_bit, .clock_polarity_bit,
        .data_order_bit, .data_wr, .data_wdata, .data_rd, .data_rdata,
        .txc_clear, .transmit_complete_flag, .receive_complete_flag,
        .tx_buffer_empty_flag, .frame_error_flag, .data_overrun_flag,
        .parity_error_flag, .serial_in_pin, .serial_out_pin,
        .serial_out_oe_n, .serial_clock_pin, .serial_clock_oe_n);

    spi_slave_model spi_slave_model_inst (.sck(serial_clock_pin),
        .mosi(serial_out_pin), .cpha(clock_phase_bit),
        .lsb_first(data_order_bit), .load(load), .tx_byte(slave_tx),
        .miso(serial_in_pin), .rx_byte(slave_rx), .frames(frames));

    // spacing of clock edges, and every byte the slave completes
    always @(serial_clock_pin) begin
        half = 16'($time - t_edge);
        t_edge = $time;
    end
    always @(frames) #1 seen.push_back(slave_rx);

    task automatic cmp(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // slave byte preset and completion flag cleared before each write
    // the byte settles a cycle before the load strobe reads it
    task automatic prep(input logic [7:0] s);
        slave_tx = s;
        txc_clear = 1'b1;
        cyc(1);
        load = 1'b1;
        txc_clear = 1'b0;
        cyc(1);
        load = 1'b0;
    endtask

    task automatic put(input logic [7:0] b);
        for (int i = 0; i < 9000 && tx_buffer_empty_flag !== 1'b1; i++)
            cyc(1);
        data_wr = 1'b1;
        data_wdata = b;
        cyc(1);
        data_wr = 1'b0;
    endtask

    task automatic wait_txc();
        for (int i = 0; i < 9000 && transmit_complete_flag !== 1'b1; i++)
            cyc(1);
        cmp("txc", 1, transmit_complete_flag);
    endtask

    task automatic get(input logic [7:0] b);
        for (int i = 0; i < 9000 && receive_complete_flag !== 1'b1; i++)
            cyc(1);
        cmp("rx data", b, data_rdata);
        data_rd = 1'b1;
        cyc(1);
        data_rd = 1'b0;
        cyc(1);
    endtask

    task automatic frame(input logic [7:0] b, input logic [7:0] s);
        prep(s);
        put(b);
        wait_txc();
        cmp("slave got", b, slave_rx);
    endtask

    task automatic complete_run();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 1 ms
    initial begin
        #2000000;
        bad_count++;
        complete_run();
    end

    // main sequence; inputs move on falling edges only
    initial begin
        // clock pin set, divisor zero at enable
        cyc(5);
        rst = 1'b0;
        cyc(2);
        cmp("empty", 1, tx_buffer_empty_flag);
        cmp("flags", 0, {transmit_complete_flag, receive_complete_flag});
        cmp("err", 0, {frame_error_flag, data_overrun_flag,
            parity_error_flag});
        cmp("oe", 0, {serial_out_oe_n, serial_clock_oe_n});
        frame(8'h1D, 8'h4D);
        cmp("half at div 0", 100, half);
        cmp("rxc off", 0, receive_complete_flag);
        $display("test reset done");
        receiver_enable_bit = 1'b1;
        for (int m = 0; m < 8; m++) begin
            {baud_divisor_high, baud_divisor_low} =
                (m == 7) ? 12'h101 : 12'(m % 3 + 2);
            {clock_polarity_bit, clock_phase_bit, data_order_bit} = 3'(m);
            cyc(3);
            frame(8'h1D + 8'(m * 17), 8'h4D ^ 8'(m));
            get(8'h4D ^ 8'(m));
            cmp("half", 16'(100 * ({baud_divisor_high,
                baud_divisor_low} + 1)), half);
            cmp("sck idle", clock_polarity_bit, serial_clock_pin);
            cmp("out idle", 1, serial_out_pin);
        end
        $display("test modes done");
        {baud_divisor_high, baud_divisor_low, clock_polarity_bit,
            clock_phase_bit, data_order_bit} = 15'h0010;
        cyc(3);
        prep(8'h5A);
        put(8'h12);
        put(8'h34);
        cyc(60);
        cmp("txc mid", 0, transmit_complete_flag);
        wait_txc();
        cmp("word hi", 8'h12, seen[seen.size() - 2]);
        cmp("word lo", 8'h34, seen[seen.size() - 1]);
        get(8'h5A);
        get(8'h5A);
        $display("test burst done");
        frame(8'h21, 8'hB1);
        frame(8'h22, 8'hB2);
        frame(8'h23, 8'hB3);
        get(8'hB1);
        get(8'hB2);
        cmp("rxc drop", 0, receive_complete_flag);
        frame(8'h31, 8'hE7);
        receiver_enable_bit = 1'b0;
        cyc(2);
        cmp("rx flush", 0, receive_complete_flag);
        receiver_enable_bit = 1'b1;
        $display("test receive buffer done");
        prep(8'h6B);
        cmp("txc clear", 0, transmit_complete_flag);
        put(8'h44);
        transmitter_enable_bit = 1'b0;
        cyc(3);
        cmp("oe busy", 0, serial_out_oe_n);
        wait_txc();
        cyc(2);
        cmp("oe off", 1, serial_out_oe_n);
        cmp("late byte", 8'h44, slave_rx);
        get(8'h6B);
        transmitter_enable_bit = 1'b1;
        clock_pin_direction = 1'b0;
        cyc(1);
        cmp("sck dir", 1, serial_clock_oe_n);
        clock_pin_direction = 1'b1;
        mode_select_low = 1'b0;
        cyc(2);
        cmp("oe mode", 3, {serial_out_oe_n, serial_clock_oe_n});
        put(8'h55);
        cyc(3);
        cmp("refused", 1, tx_buffer_empty_flag);
        mode_select_low = 1'b1;
        $display("test enables done");
        complete_run();
    end
endmodule
